/* File: core/dic_consts.svh */
// Behaviour
// - Reference is XLR, coax, internal 48k or 44.1k.
// - Internal reference selected disables the digital input.
// - Locked external input reports rate and pro/consumer format.
// - Lost lock or non-audio mutes, falls back internally.
// - Fallback keeps retrying and returns once lock confirmed.
// - Rate beyond four percent raises error and mutes.
// - Non-audio stream flags error and mutes while present.
// - Lost lock raises error and mutes while lost.
// - Fallback also raises a separate user error indication.
// - Input monitor updates live, even on internal reference.
// - Monitor shows emphasis; pro covers both emphasis codes.
// - Monitor shows lock lost and substituted internal rate.
// - Each error type counted separately, saturating with overflow.
// - Counts clear at reset, relock and external reselect.
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

// Register byte addresses, one aligned word each.
`define DIC_A_CTRL 8'h00
`define DIC_A_STAT 8'h04
`define DIC_A_IRQ_ST 8'h08
`define DIC_A_IRQ_CLR 8'h0C
`define DIC_A_IRQ_EN 8'h10
`define DIC_A_CNT_LOCK 8'h14
`define DIC_A_CNT_RANGE 8'h18
`define DIC_A_CNT_NONAUD 8'h1C

// Reference selection codes held in the control register.
`define DIC_REF_XLR 2'h0
`define DIC_REF_COAX 2'h1
`define DIC_REF_INT48 2'h2
`define DIC_REF_INT44 2'h3
`define DIC_REF_RESET 2'h2
`define DIC_CTRL_DISMISS 8

// Live status register fields.
`define DIC_ST_LOCKED 0
`define DIC_ST_FALLBACK 1
`define DIC_ST_PRO 2
`define DIC_ST_EMPH 3
`define DIC_ST_RATE44 4
`define DIC_ST_MUTED 5
`define DIC_ST_IN44 6
`define DIC_ST_IN48 7
`define DIC_ST_PER_LSB 16

// Event bits shared by the interrupt registers and the counters.
`define DIC_EV_LOCK 0
`define DIC_EV_RANGE 1
`define DIC_EV_NONAUD 2
`define DIC_EV_RELOCK 3
`define DIC_CNT_OVF 15

// Emphasis codes: pro field of three bits, consumer flag bit.
`define DIC_EMPH_PRO_5015 3'h6
`define DIC_EMPH_PRO_CCITT 3'h7
`define DIC_EMPH_CNS_BIT 0

// Timing: clock rate, nominal rates, tolerance in percent.
`define DIC_SYS_HZ 25000000
`define DIC_FS48_HZ 48000
`define DIC_FS44_HZ 44100
`define DIC_TOL_PCT 4
`define DIC_CNT_MAX 9999
`define DIC_LOCK_FRAMES 8

`endif

/* File: core/dic_pkg.sv */
package dic_pkg;
  // Supervisor states: internal reference, acquiring, locked.
  typedef enum logic [1:0] {
    DIC_S_INT,
    DIC_S_ACQ,
    DIC_S_LOCK
  } dic_state_t;
endpackage : dic_pkg

/* File: core/dic_cnt_if.sv */
// Event, clear and value of one saturating error counter.
interface dic_cnt_if;
  logic clr;
  logic evt;
  logic [13:0] count;
  logic ovf;
  modport ctl (output clr, output evt, input count, input ovf);
  modport cnt (input clr, input evt, output count, output ovf);
endinterface : dic_cnt_if

/* File: core/dic_sync.sv */
module dic_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two stages; only the second stage is visible to logic.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : dic_sync

/* File: core/dic_errcnt.sv */
`include "dic_consts.svh"
module dic_errcnt #(
  parameter logic [13:0] MAX = 14'(`DIC_CNT_MAX)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  dic_cnt_if.cnt port
);
  // Count stops at the maximum; further events only raise overflow.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || port.clr) begin
      port.count <= '0;
      port.ovf <= 1'b0;
    end else if (port.evt) begin
      if (port.count == MAX) begin
        port.ovf <= 1'b1;
      end else begin
        port.count <= port.count + 14'h0001;
      end
    end
  end
endmodule : dic_errcnt

/* File: core/dic_supervisor.sv */
// The strobed register port and the register addresses were chosen for this implementation.
`include "dic_consts.svh"
module dic_supervisor
  import dic_pkg::*;
#(
  parameter int LOCK_FRAMES = `DIC_LOCK_FRAMES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_clk,
  input wire logic rx_fsync,
  input wire logic rx_nonaudio,
  input wire logic rx_pro,
  input wire logic [2:0] rx_emph_code,
  output logic clk_use_ext,
  output logic int_rate_44k,
  output logic coax_sel,
  output logic dig_in_en,
  output logic dig_in_mute,
  output logic err_ind,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////
  // Frame period limits in system clock cycles.

  localparam int P48 = `DIC_SYS_HZ / `DIC_FS48_HZ;
  localparam int P44 = `DIC_SYS_HZ / `DIC_FS44_HZ;
  localparam logic [11:0] LO48 = 12'((P48 * (100 - `DIC_TOL_PCT)) / 100);
  localparam logic [11:0] HI48 = 12'((P48 * (100 + `DIC_TOL_PCT)) / 100);
  localparam logic [11:0] LO44 = 12'((P44 * (100 - `DIC_TOL_PCT)) / 100);
  localparam logic [11:0] HI44 = 12'((P44 * (100 + `DIC_TOL_PCT)) / 100);
  // Two slow frames without a frame mark means the source is gone.
  localparam logic [11:0] TIMEOUT = 12'(2 * P44);
  localparam logic [3:0] STAB_LAST = 4'(LOCK_FRAMES - 1);

  //////////////////////////////////////////////////////////////////////////
  // Link pin synchronisation and edge detection.

  logic [6:0] pin_s;
  logic rxclk_s;
  logic fsync_s;
  logic nonaud_s;
  logic pro_s;
  logic [2:0] emph_s;
  logic rxclk_prev_q;
  logic fsync_prev_q;
  logic rx_edge;
  logic fs_edge;

  dic_sync #(.W(7)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({rx_clk, rx_fsync, rx_nonaudio, rx_pro, rx_emph_code}),
    .q(pin_s)
  );

  assign {rxclk_s, fsync_s, nonaud_s, pro_s, emph_s} = pin_s;

  // The link clock is only sampled, so its rising edge is a one-cycle pulse.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxclk_prev_q <= 1'b0;
    end else begin
      rxclk_prev_q <= rxclk_s;
    end
  end

  assign rx_edge = rxclk_s & ~rxclk_prev_q;

  // Frame mark is taken on link clock edges so glitches between bits are ignored.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fsync_prev_q <= 1'b0;
    end else if (rx_edge) begin
      fsync_prev_q <= fsync_s;
    end
  end

  assign fs_edge = rx_edge & fsync_s & ~fsync_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Frame period measurement and rate classification.

  logic [11:0] per_cnt_q;
  logic [11:0] per_meas_q;
  logic have_ref_q;
  logic timeout;
  logic in48;
  logic in44;
  logic rate_ok;
  logic good_frame;
  logic bad_frame;

  assign timeout = (per_cnt_q >= TIMEOUT);
  assign in48 = (per_cnt_q >= LO48) && (per_cnt_q <= HI48);
  assign in44 = (per_cnt_q >= LO44) && (per_cnt_q <= HI44);
  assign rate_ok = in48 | in44;
  assign good_frame = fs_edge & have_ref_q & rate_ok & ~nonaud_s;
  assign bad_frame = fs_edge & have_ref_q & ~good_frame;

  // Counter saturates at the timeout so a dead link holds it there.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      per_cnt_q <= 12'h000;
      per_meas_q <= 12'h000;
      have_ref_q <= 1'b0;
    end else if (fs_edge) begin
      per_cnt_q <= 12'h001;
      per_meas_q <= have_ref_q ? per_cnt_q : 12'h000;
      have_ref_q <= 1'b1;
    end else if (timeout) begin
      per_meas_q <= 12'h000;
      have_ref_q <= 1'b0;
    end else begin
      per_cnt_q <= per_cnt_q + 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Live input monitor, kept up even on the internal reference.

  logic pro_q;
  logic emph_q;
  logic nonaud_q;
  logic range_bad_q;
  logic meas44_q;
  logic meas48_q;
  logic emph_now;

  // Pro streams count either emphasis code as emphasis present.
  assign emph_now = pro_s ?
    ((emph_s == `DIC_EMPH_PRO_5015) || (emph_s == `DIC_EMPH_PRO_CCITT)) :
    emph_s[`DIC_EMPH_CNS_BIT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pro_q <= 1'b0;
      emph_q <= 1'b0;
      nonaud_q <= 1'b0;
      meas44_q <= 1'b0;
      meas48_q <= 1'b0;
    end else if (fs_edge) begin
      pro_q <= pro_s;
      emph_q <= emph_now;
      nonaud_q <= nonaud_s;
      meas44_q <= have_ref_q & in44;
      meas48_q <= have_ref_q & in48;
    end else if (timeout) begin
      nonaud_q <= 1'b0;
      meas44_q <= 1'b0;
      meas48_q <= 1'b0;
    end
  end

  // Rate_tolerance_error stays until a frame of good length arrives or the link times out.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      range_bad_q <= 1'b0;
    end else if (fs_edge && have_ref_q) begin
      range_bad_q <= ~rate_ok;
    end else if (timeout) begin
      range_bad_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes: reference selection and dismiss.

  logic [1:0] ref_sel_q;
  logic ctrl_wr;
  logic ref_ext;
  logic reselect;
  logic dismiss;

  assign ctrl_wr = reg_wr && (reg_addr == `DIC_A_CTRL);
  assign ref_ext = (ref_sel_q == `DIC_REF_XLR) ||
                   (ref_sel_q == `DIC_REF_COAX);
  assign reselect = ctrl_wr && ((reg_wdata[1:0] == `DIC_REF_XLR) ||
                                (reg_wdata[1:0] == `DIC_REF_COAX));
  assign dismiss = ctrl_wr && reg_wdata[`DIC_CTRL_DISMISS];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_sel_q <= `DIC_REF_RESET;
    end else if (ctrl_wr) begin
      ref_sel_q <= reg_wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference state machine with fallback and automatic relock.

  dic_state_t state_q;
  logic [3:0] stab_q;
  logic lock_loss;
  logic relock;

  // Loss of lock is a timeout or a non-audio frame while locked.
  assign lock_loss = (state_q == DIC_S_LOCK) &&
                     (timeout || (fs_edge && nonaud_s));
  assign relock = (state_q == DIC_S_ACQ) && good_frame &&
                  (stab_q == STAB_LAST);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= DIC_S_INT;
    end else if (ctrl_wr) begin
      state_q <= reselect ? DIC_S_ACQ : DIC_S_INT;
    end else begin
      unique case (state_q)
        DIC_S_INT: state_q <= DIC_S_INT;
        DIC_S_ACQ: if (relock) state_q <= DIC_S_LOCK;
        DIC_S_LOCK: if (lock_loss) state_q <= DIC_S_ACQ;
      endcase
    end
  end

  // Any bad or missing frame restarts the count of stable frames.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_q != DIC_S_ACQ || ctrl_wr) begin
      stab_q <= 4'h0;
    end else if (bad_frame || timeout || relock) begin
      stab_q <= 4'h0;
    end else if (good_frame) begin
      stab_q <= stab_q + 4'h1;
    end
  end

  // Rate in use: the chosen internal one, else the last valid external.
  logic rate44_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rate44_q <= 1'b0;
    end else if (!ref_ext) begin
      rate44_q <= (ref_sel_q == `DIC_REF_INT44);
    end else if (state_q == DIC_S_LOCK && good_frame) begin
      rate44_q <= in44;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events, error counters and the user error indication.

  logic [3:0] evt;
  logic range_prev_q;
  logic nonaud_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      range_prev_q <= 1'b0;
      nonaud_prev_q <= 1'b0;
    end else begin
      range_prev_q <= range_bad_q;
      nonaud_prev_q <= nonaud_q;
    end
  end

  assign evt[`DIC_EV_LOCK] = lock_loss & timeout;
  assign evt[`DIC_EV_RANGE] = ref_ext & range_bad_q & ~range_prev_q;
  assign evt[`DIC_EV_NONAUD] = ref_ext & nonaud_q & ~nonaud_prev_q;
  assign evt[`DIC_EV_RELOCK] = relock;

  logic cnt_clr;
  logic [15:0] cnt_word [0:2];
  assign cnt_clr = relock | reselect;

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    dic_cnt_if cif ();
    assign cif.clr = cnt_clr;
    assign cif.evt = evt[i];
    assign cnt_word[i] = {cif.ovf, 1'b0, cif.count};
    dic_errcnt u_cnt (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .port(cif.cnt)
    );
  end

  // The message stays until dismissed, even after the input recovers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      err_ind <= 1'b0;
    end else if (lock_loss || evt[`DIC_EV_RANGE]) begin
      err_ind <= 1'b1;
    end else if (dismiss) begin
      err_ind <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear.

  logic [3:0] irq_st_q;
  logic [3:0] irq_en_q;
  logic [3:0] irq_clr;

  assign irq_clr = (reg_wr && reg_addr == `DIC_A_IRQ_CLR) ?
                   reg_wdata[3:0] : 4'h0;

  // Set wins over clear so an event in the clearing cycle survives.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_st_q <= 4'h0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | evt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en_q <= 4'h0;
    end else if (reg_wr && reg_addr == `DIC_A_IRQ_EN) begin
      irq_en_q <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_st_q & irq_en_q);

  //////////////////////////////////////////////////////////////////////////
  // Outputs toward the audio path and the clock generator.

  assign clk_use_ext = (state_q == DIC_S_LOCK);
  assign int_rate_44k = rate44_q;
  assign coax_sel = (ref_sel_q == `DIC_REF_COAX);
  assign dig_in_en = ref_ext;
  // Muted whenever not locked, rate_tolerance_error or carrying non-audio data.
  assign dig_in_mute = (state_q != DIC_S_LOCK) | range_bad_q |
                       nonaud_q;

  //////////////////////////////////////////////////////////////////////////
  // Register read port: data in the cycle after the strobe.

  logic [31:0] stat_word;
  logic [31:0] rd_d;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`DIC_ST_LOCKED] = (state_q == DIC_S_LOCK);
    stat_word[`DIC_ST_FALLBACK] = (state_q == DIC_S_ACQ);
    stat_word[`DIC_ST_PRO] = pro_q;
    stat_word[`DIC_ST_EMPH] = emph_q;
    stat_word[`DIC_ST_RATE44] = rate44_q;
    stat_word[`DIC_ST_MUTED] = dig_in_mute;
    stat_word[`DIC_ST_IN44] = meas44_q;
    stat_word[`DIC_ST_IN48] = meas48_q;
    stat_word[`DIC_ST_PER_LSB +: 12] = per_meas_q;
  end

  always_comb begin
    unique case (reg_addr)
      `DIC_A_CTRL: rd_d = {30'h0, ref_sel_q};
      `DIC_A_STAT: rd_d = stat_word;
      `DIC_A_IRQ_ST: rd_d = {28'h0, irq_st_q};
      `DIC_A_IRQ_EN: rd_d = {28'h0, irq_en_q};
      `DIC_A_CNT_LOCK: rd_d = {16'h0, cnt_word[`DIC_EV_LOCK]};
      `DIC_A_CNT_RANGE: rd_d = {16'h0, cnt_word[`DIC_EV_RANGE]};
      `DIC_A_CNT_NONAUD: rd_d = {16'h0, cnt_word[`DIC_EV_NONAUD]};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
    end
  end

endmodule : dic_supervisor

/* File: tb/dic_supervisor_chk.sv */
module dic_supervisor_chk #(
  parameter int LOCK_FRAMES = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic clk_use_ext,
  input wire logic coax_sel,
  input wire logic dig_in_en,
  input wire logic dig_in_mute,
  input wire logic err_ind
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_WAIT = (LOCK_FRAMES - 1) * 499;
  logic [15:0] acq_q;
  logic ctrl_wr;
  // A control write restarts acquisition, so it restarts the wait too.
  assign ctrl_wr = reg_wr && reg_addr == 8'h00;
  // Cycles spent acquiring; saturates so a long outage cannot wrap it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || clk_use_ext || !dig_in_en || ctrl_wr) begin
      acq_q <= 16'h0000;
    end else if (acq_q != 16'hFFFF) begin
      acq_q <= acq_q + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  int_ref_off_a: assert property (
    !dig_in_en |-> !clk_use_ext && dig_in_mute)
    else $error("internal reference left input live");
  mute_unlock_a: assert property (
    !clk_use_ext |-> dig_in_mute) else $error("unmuted without lock");
  coax_ext_a: assert property (
    coax_sel |-> dig_in_en) else $error("coax chosen but input off");
  relock_ext_a: assert property (
    $rose(clk_use_ext) |-> dig_in_en && !dig_in_mute)
    else $error("relock without unmute");
  lock_wait_a: assert property (
    $rose(clk_use_ext) |-> $past(acq_q) >= MIN_WAIT)
    else $error("lock confirmed too early");
  fall_err_a: assert property (
    $fell(clk_use_ext) && dig_in_en && !$past(ctrl_wr) |-> ##[0:2] err_ind)
    else $error("fallback without error indication");
  err_sticky_a: assert property (
    err_ind && !(ctrl_wr && reg_wdata[8]) |=> err_ind)
    else $error("error indication dropped undismissed");
  cnt_sat_a: assert property (
    reg_rd && reg_addr >= 8'h14 && reg_addr <= 8'h1C && reg_addr[1:0] == 2'h0
    |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[14] == 1'b0
    && reg_rdata[13:0] <= 14'h270F) else $error("count beyond limit");
  stat_mirror_a: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[5] == $past(dig_in_mute)
    && reg_rdata[0] == $past(clk_use_ext)) else $error("status disagrees");
endmodule : dic_supervisor_chk

bind dic_supervisor dic_supervisor_chk #(.LOCK_FRAMES(LOCK_FRAMES)) chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clk_use_ext(clk_use_ext), .coax_sel(coax_sel),
  .dig_in_en(dig_in_en), .dig_in_mute(dig_in_mute), .err_ind(err_ind));

/* File: tb/dic_tx_model.sv */
module dic_tx_model (
  input wire logic en,
  input wire logic [9:0] bit_ns,
  input wire logic nonaudio,
  input wire logic pro,
  input wire logic [2:0] emph,
  output logic rx_clk,
  output logic rx_fsync,
  output logic rx_nonaudio,
  output logic rx_pro,
  output logic [2:0] rx_emph_code,
  output int frames
);
  timeunit 1ns;
  timeprecision 100ps;
  int b;
  // Idle lines at start.
  initial begin
    rx_clk = 1'b0;
    rx_fsync = 1'b0;
    rx_nonaudio = 1'b0;
    rx_pro = 1'b0;
    rx_emph_code = 3'h0;
    frames = 0;
  end
  // Sixty-four bit frames; the bit clock stands still while disabled, as
  // an unplugged source would leave it, which is what makes lock drop.
  always begin
    if (en !== 1'b1) begin
      #50;
    end else begin
      for (b = 0; b < 64; b++) begin
        rx_fsync = (b == 0);
        if (b == 0) begin
          rx_nonaudio = nonaudio;
          rx_pro = pro;
          rx_emph_code = emph;
        end
        #(bit_ns / 2) rx_clk = 1'b1;
        #(bit_ns - bit_ns / 2) rx_clk = 1'b0;
      end
      frames++;
    end
  end
endmodule : dic_tx_model

/* File: tb/dic_supervisor_tb.sv */
module dic_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic rx_clk, rx_fsync, rx_nonaudio, rx_pro;
  logic [2:0] rx_emph_code;
  logic clk_use_ext, int_rate_44k, coax_sel, dig_in_en, dig_in_mute;
  logic err_ind, irq;
  logic en = 1'b0;
  logic nonaud = 1'b0;
  logic pro = 1'b1;
  logic [9:0] bit_ns = 10'h140;
  logic [2:0] emph = 3'h6;
  logic [2:0] ecode [3] = '{3'h7, 3'h1, 3'h6};
  logic epro [3] = '{1'b1, 1'b0, 1'b0};
  logic eexp [3] = '{1'b1, 1'b1, 1'b0};
  int frames, i, k;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] d;

  // Clock at 25 MHz.
  always #20 sys_clk = ~sys_clk;

  dic_supervisor #(.LOCK_FRAMES(4)) dic_supervisor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_clk(rx_clk), .rx_fsync(rx_fsync),
    .rx_nonaudio(rx_nonaudio), .rx_pro(rx_pro),
    .rx_emph_code(rx_emph_code), .clk_use_ext(clk_use_ext),
    .int_rate_44k(int_rate_44k), .coax_sel(coax_sel), .dig_in_en(dig_in_en),
    .dig_in_mute(dig_in_mute), .err_ind(err_ind), .irq(irq));

  dic_tx_model dic_tx_model_i (
    .en(en), .bit_ns(bit_ns), .nonaudio(nonaud), .pro(pro), .emph(emph),
    .rx_clk(rx_clk), .rx_fsync(rx_fsync), .rx_nonaudio(rx_nonaudio),
    .rx_pro(rx_pro), .rx_emph_code(rx_emph_code), .frames(frames));

  ////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, e, g);
    end
  endtask : chk

  // Strobes last one cycle; the short delay lets the answering edge land.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Waits for n frames, then for the next frame start to be seen.
  task automatic nf(input int n);
    int t0;
    t0 = frames;
    for (int j = 0; j < n * 800 && frames < t0 + n; j++) @(posedge sys_clk);
    if (frames < t0 + n) begin
      n_errors++;
      wrap_up();
    end
    repeat (12) @(posedge sys_clk);
    #1;
  endtask : nf

  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    rd(8'h04, d);
    chk("muted", 1, d[5]);
    chk("dig_in_en", 0, dig_in_en);
    nf(3);
    rd(8'h04, d);
    chk("in48", 1, d[7]);
    // Sixty-four bits of 320 ns are exactly 512 system clock cycles.
    chk("period", 32'h200, d[27:16]);
    chk("ext", 0, clk_use_ext);
    $display("internal reference test done");
    wr(8'h00, 32'h0);
    chk("coax_sel", 0, coax_sel);
    chk("dig_in_en", 1, dig_in_en);
    nf(2);
    chk("early lock", 0, clk_use_ext);
    nf(5);
    chk("ext", 1, clk_use_ext);
    rd(8'h04, d);
    chk("status", 32'h8D, d & 32'hFF);
    rd(8'h08, d);
    chk("relock event", 1, d[3]);
    wr(8'h10, 32'h8);
    chk("irq", 1, irq);
    wr(8'h0C, 32'hF);
    chk("irq", 0, irq);
    wr(8'h10, 32'h7);
    for (i = 0; i < 3; i++) begin
      pro <= epro[i];
      emph <= ecode[i];
      nf(2);
      rd(8'h04, d);
      chk("pro", epro[i], d[2]);
      chk("emph", eexp[i], d[3]);
    end
    $display("lock test done");
    nonaud <= 1'b1;
    nf(1);
    chk("mute", 1, dig_in_mute);
    chk("ext", 0, clk_use_ext);
    chk("err_ind", 1, err_ind);
    chk("rate44", 0, int_rate_44k);
    chk("irq", 1, irq);
    rd(8'h1C, d);
    chk("nonaudio count", 1, d);
    nonaud <= 1'b0;
    bit_ns <= 10'h162;
    nf(8);
    chk("ext", 1, clk_use_ext);
    rd(8'h04, d);
    chk("in44", 1, d[6]);
    rd(8'h1C, d);
    chk("nonaudio count", 0, d);
    $display("non-audio test done");
    en <= 1'b0;
    for (k = 0; k < 2000 && clk_use_ext === 1'b1; k++) @(posedge sys_clk);
    // A lock that does not drop within 2000 cycles ends the run here.
    if (clk_use_ext !== 1'b0) begin
      n_errors++;
      wrap_up();
    end
    #1;
    chk("ext", 0, clk_use_ext);
    chk("rate44", 1, int_rate_44k);
    chk("mute", 1, dig_in_mute);
    rd(8'h14, d);
    chk("lock count", 1, d);
    rd(8'h08, d);
    chk("lock event", 1, d[0]);
    rd(8'h04, d);
    chk("status", 32'h32, d & 32'h33);
    $display("lock loss test done");
    wr(8'h00, 32'h101);
    chk("coax_sel", 1, coax_sel);
    chk("err_ind", 0, err_ind);
    rd(8'h14, d);
    chk("lock count", 0, d);
    bit_ns <= 10'h140;
    en <= 1'b1;
    nf(6);
    chk("ext", 1, clk_use_ext);
    bit_ns <= 10'h118;
    nf(2);
    chk("mute", 1, dig_in_mute);
    chk("err_ind", 1, err_ind);
    rd(8'h18, d);
    chk("range count", 1, d);
    rd(8'h08, d);
    chk("range event", 1, d[1]);
    $display("range test done");
    rd(8'h40, d);
    chk("unmapped", 0, d);
    wr(8'h00, 32'h3);
    chk("dig_in_en", 0, dig_in_en);
    // The internal rate follows the new selection one cycle after the write.
    @(posedge sys_clk);
    #1;
    chk("rate44", 1, int_rate_44k);
    chk("mute", 1, dig_in_mute);
    $display("reselect test done");
    wrap_up();
  end
endmodule : dic_supervisor_tb
